/* obcfg_defs.svh */
`ifndef OBCFG_DEFS_SVH
`define OBCFG_DEFS_SVH

// ****************************************************************
// Register indices; the byte address is four times the index.
// ****************************************************************
`define OBCFG_IDX_LEVEL_LOW   6'h04
`define OBCFG_IDX_LEVEL_MID   6'h05
`define OBCFG_IDX_BIAS_SET    6'h06
`define OBCFG_IDX_LOGIC_DRV   6'h07
`define OBCFG_IDX_LOGIC_FMT   6'h08
`define OBCFG_NUM_WORDS       5

// ****************************************************************
// Reset values and writable-bit masks.
// ****************************************************************
`define OBCFG_RST_LEVEL_LOW   16'h36ff
`define OBCFG_RST_LEVEL_MID   16'h4936
`define OBCFG_RST_BIAS_SET    16'hb6dc
`define OBCFG_RST_LOGIC_DRV   16'h0001
`define OBCFG_RST_LOGIC_FMT   16'h0120
`define OBCFG_WM_LEVEL_LOW    16'h3fff
`define OBCFG_WM_LEVEL_MID    16'h7fff
`define OBCFG_WM_BIAS_SET     16'hffff
`define OBCFG_WM_LOGIC_DRV    16'h7fff
`define OBCFG_WM_LOGIC_FMT    16'h01ff

// ****************************************************************
// Field positions (least significant bit).
// ****************************************************************
`define OBCFG_F_MAIN_ON       0
`define OBCFG_F_REF_ON        4
`define OBCFG_F_MAIN0_LVL     8
`define OBCFG_F_MAIN1_LVL     11
`define OBCFG_F_MAIN2_LVL     0
`define OBCFG_F_MAIN3_LVL     3
`define OBCFG_F_REF0_LVL      6
`define OBCFG_F_REF1_LVL      9
`define OBCFG_F_REF2_LVL      12
`define OBCFG_F_REF3_LVL      0
`define OBCFG_F_REF0_BIAS     3
`define OBCFG_F_REF1_BIAS     6
`define OBCFG_F_REF2_BIAS     9
`define OBCFG_F_REF3_BIAS     12
`define OBCFG_F_FCLK_ON       15
`define OBCFG_F_FREF_ON       0
`define OBCFG_F_FCLK_LVL      1
`define OBCFG_F_FREF_LVL      4
`define OBCFG_F_FCLK_PRE      7
`define OBCFG_F_FREF_PRE      9
`define OBCFG_F_FCLK_BIAS     11
`define OBCFG_F_FREF_BIAS     13
`define OBCFG_F_FCLK_FMT      0
`define OBCFG_F_FREF_FMT      2
`define OBCFG_F_FSUB_ON       5
`define OBCFG_F_FPRE_DIV      6

// ****************************************************************
// Driver format codes.
// ****************************************************************
`define OBCFG_FMT_LVDS        2'h0
`define OBCFG_FMT_CML         2'h2

`endif

/* obcfg_pkg.sv */
package obcfg_pkg;

	// ****************************************************************
	// Static control levels toward the analog output drivers.
	// ****************************************************************
	typedef struct packed {
		logic [3:0]      main_out_on;
		logic [3:0]      frame_ref_on;
		logic [3:0][2:0] main_out_level;
		logic [3:0][2:0] frame_ref_level;
		logic [3:0][2:0] frame_ref_bias;
		logic            fabric_clk_on;
		logic            fabric_ref_on;
		logic [1:0]      fabric_clk_bias;
		logic [1:0]      fabric_ref_bias;
		logic [1:0]      fabric_clk_predrive;
		logic [1:0]      fabric_ref_predrive;
		logic [2:0]      fabric_clk_level;
		logic [2:0]      fabric_ref_level;
		logic [1:0]      fabric_clk_driver_type;
		logic [1:0]      fabric_ref_driver_type;
		logic            fabric_subsys_on;
		logic [2:0]      fabric_pre_div;
	} obcfg_drive_t;

	typedef logic [4:0][15:0] obcfg_words_t;

endpackage

/* obcfg_regs.sv */
`timescale 1ns/100ps
`include "obcfg_defs.svh"

// Operation
// R1: Software writes zero into reserved fields.
// R2: Main output 1 level, bits 13-11, reset 6.
// R3: Main output 0 level, bits 10-8, reset 6.
// R4: Frame reference enables 3..0 in bits 7..4.
// R5: Main output enables 3..0 in bits 3..0.
// R6: Word 5 resets 0x4936, main levels 3,2.
// R7: Word 5 holds frame reference levels 2..0.
// R8: Software pairs each level with its bias.
// R9: Word 6 resets 0xb6dc, clock enable, level 3.
// R10: Word 6 holds frame reference biases 3..0.
// R11: Word 7 resets 0x0001, bit 0 reference enable.
// R12: Fabric reference bias applies only in LVDS.
// R13: Fabric clock bias applies only in LVDS.
// R14: Fabric reference predrive, bits 10-9, reset 0.
// R15: Fabric clock predrive, bits 8-7, reset 0.
// R16: Fabric reference level applies only in CML.
// R17: Fabric clock level applies only in CML.
// R18: Word 8 resets to 0x0120.
// R19: Driver type 0 LVDS, 2 CML, else reserved.
// R20: Outputs follow stored fields, reset restores them.

module obcfg_regs
	import obcfg_pkg::*;
(
	// Clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// APB slave
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [7:0]   paddr,
	input  wire logic [31:0]  pwdata,
	input  wire logic [3:0]   pstrb,
	output logic      [31:0]  prdata,
	output logic              pready,
	output logic              pslverr,
	// Analog driver controls
	output obcfg_drive_t      drive
);

	// ****************************************************************
	// Constants.
	// ****************************************************************
	localparam obcfg_words_t RST_WORDS = {
		`OBCFG_RST_LOGIC_FMT, `OBCFG_RST_LOGIC_DRV, `OBCFG_RST_BIAS_SET,
		`OBCFG_RST_LEVEL_MID, `OBCFG_RST_LEVEL_LOW};
	localparam obcfg_words_t WR_MASK = {
		`OBCFG_WM_LOGIC_FMT, `OBCFG_WM_LOGIC_DRV, `OBCFG_WM_BIAS_SET,
		`OBCFG_WM_LEVEL_MID, `OBCFG_WM_LEVEL_LOW};

	// ****************************************************************
	// Field decode from the stored words to driver controls.
	// ****************************************************************
	function automatic obcfg_drive_t decode(input obcfg_words_t w);
		obcfg_drive_t d;
		logic [1:0]   clk_fmt;
		logic [1:0]   ref_fmt;
		d = '0;
		clk_fmt = w[4][`OBCFG_F_FCLK_FMT +: 2];
		ref_fmt = w[4][`OBCFG_F_FREF_FMT +: 2];
		d.main_out_on        = w[0][`OBCFG_F_MAIN_ON +: 4];      // [R5]
		d.frame_ref_on       = w[0][`OBCFG_F_REF_ON +: 4];       // [R4]
		d.main_out_level[0]  = w[0][`OBCFG_F_MAIN0_LVL +: 3];    // [R3]
		d.main_out_level[1]  = w[0][`OBCFG_F_MAIN1_LVL +: 3];    // [R2]
		d.main_out_level[2]  = w[1][`OBCFG_F_MAIN2_LVL +: 3];    // [R6]
		d.main_out_level[3]  = w[1][`OBCFG_F_MAIN3_LVL +: 3];    // [R6]
		d.frame_ref_level[0] = w[1][`OBCFG_F_REF0_LVL +: 3];     // [R7]
		d.frame_ref_level[1] = w[1][`OBCFG_F_REF1_LVL +: 3];     // [R7]
		d.frame_ref_level[2] = w[1][`OBCFG_F_REF2_LVL +: 3];     // [R7]
		d.frame_ref_level[3] = w[2][`OBCFG_F_REF3_LVL +: 3];     // [R9]
		d.frame_ref_bias[0]  = w[2][`OBCFG_F_REF0_BIAS +: 3];    // [R10]
		d.frame_ref_bias[1]  = w[2][`OBCFG_F_REF1_BIAS +: 3];    // [R10]
		d.frame_ref_bias[2]  = w[2][`OBCFG_F_REF2_BIAS +: 3];    // [R10]
		d.frame_ref_bias[3]  = w[2][`OBCFG_F_REF3_BIAS +: 3];    // [R10]
		d.fabric_clk_on      = w[2][`OBCFG_F_FCLK_ON];           // [R9]
		d.fabric_ref_on      = w[3][`OBCFG_F_FREF_ON];           // [R11]
		d.fabric_clk_predrive = w[3][`OBCFG_F_FCLK_PRE +: 2];    // [R15]
		d.fabric_ref_predrive = w[3][`OBCFG_F_FREF_PRE +: 2];    // [R14]
		d.fabric_clk_driver_type = clk_fmt;                      // [R19]
		d.fabric_ref_driver_type = ref_fmt;                      // [R19]
		d.fabric_subsys_on   = w[4][`OBCFG_F_FSUB_ON];
		d.fabric_pre_div     = w[4][`OBCFG_F_FPRE_DIV +: 3];
		// Bias is only meaningful to a low-swing differential driver.
		if (clk_fmt == `OBCFG_FMT_LVDS) begin
			d.fabric_clk_bias = w[3][`OBCFG_F_FCLK_BIAS +: 2];   // [R13]
		end
		if (ref_fmt == `OBCFG_FMT_LVDS) begin
			d.fabric_ref_bias = w[3][`OBCFG_F_FREF_BIAS +: 2];   // [R12]
		end
		// Output level is only meaningful to a current-mode driver.
		if (clk_fmt == `OBCFG_FMT_CML) begin
			d.fabric_clk_level = w[3][`OBCFG_F_FCLK_LVL +: 3];   // [R17]
		end
		if (ref_fmt == `OBCFG_FMT_CML) begin
			d.fabric_ref_level = w[3][`OBCFG_F_FREF_LVL +: 3];   // [R16]
		end
		return d;
	endfunction

	localparam obcfg_drive_t RST_DRIVE = decode(RST_WORDS);

	// ****************************************************************
	// APB decode.
	// ****************************************************************
	obcfg_words_t words_q;
	logic [2:0]   sel_idx;
	logic         hit;
	logic [15:0]  lane_mask;
	logic         wr_en;
	logic         pready_q;
	logic         pslverr_q;
	logic [31:0]  prdata_q;
	obcfg_drive_t drive_q;

	always_comb begin
		sel_idx = 3'h0;
		hit     = 1'b0;
		if (paddr[1:0] == 2'h0 && paddr[7:2] >= `OBCFG_IDX_LEVEL_LOW &&
		    paddr[7:2] <= `OBCFG_IDX_LOGIC_FMT) begin
			hit     = 1'b1;
			sel_idx = 3'(paddr[7:2] - `OBCFG_IDX_LEVEL_LOW);
		end
	end

	assign lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
	assign wr_en     = psel & penable & pwrite & pready_q & hit;

	// One wait-free access phase: ready rises with every access phase.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q  <= psel & ~penable;
			pslverr_q <= psel & ~penable & ~hit;
		end
	end

	// Read data is captured in the setup cycle; reserved bits read zero.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
		end else if (psel && !penable) begin
			prdata_q <= (hit && !pwrite) ? {16'h0000, words_q[sel_idx]}
			                             : 32'h0000_0000;          // [R18]
		end
	end

	// ****************************************************************
	// Register words; read-only reserved bits ignore writes.
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			words_q <= RST_WORDS;                     // [R6] [R9] [R11] [R18]
		end else if (wr_en) begin
			for (int i = 0; i < `OBCFG_NUM_WORDS; i++) begin
				if (sel_idx == 3'(i)) begin
					words_q[i] <= (words_q[i] & ~(WR_MASK[i] & lane_mask)) |
					              (pwdata[15:0] & WR_MASK[i] & lane_mask);
				end
			end
		end
	end

	// ****************************************************************
	// Driver controls, registered from the stored words.
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			drive_q <= RST_DRIVE;                                    // [R20]
		end else begin
			drive_q <= decode(words_q);                              // [R20]
		end
	end

	assign prdata  = prdata_q;
	assign pready  = pready_q;
	assign pslverr = pslverr_q;
	assign drive   = drive_q;

	// ****************************************************************
	// Assertions.
	// ****************************************************************
	logic wr_low_hi;
	logic wr_low_lo;
	logic wr_mid;
	logic wr_bias;
	logic wr_logic;
	assign wr_low_hi = wr_en && sel_idx == 3'h0 && pstrb[1];
	assign wr_low_lo = wr_en && sel_idx == 3'h0 && pstrb[0];
	assign wr_mid    = wr_en && sel_idx == 3'h1 && (&pstrb[1:0]);
	assign wr_bias   = wr_en && sel_idx == 3'h2 && (&pstrb[1:0]);
	assign wr_logic  = wr_en && sel_idx == 3'h3 && (&pstrb[1:0]);

	chk_main1_level: assert property ( // [R2]
		@(posedge pclk) disable iff (!presetn)
		wr_low_hi |-> ##2 drive.main_out_level[1] == $past(pwdata[13:11], 2))
		else $error("main output 1 level not taken from write");

	chk_main0_level: assert property ( // [R3]
		@(posedge pclk) disable iff (!presetn)
		wr_low_hi |-> ##2 drive.main_out_level[0] == $past(pwdata[10:8], 2))
		else $error("main output 0 level not taken from write");

	chk_enables_write: assert property ( // [R4]
		@(posedge pclk) disable iff (!presetn)
		wr_low_lo |-> ##2 drive.frame_ref_on == $past(pwdata[7:4], 2) &&
		                  drive.main_out_on == $past(pwdata[3:0], 2))
		else $error("output enables not taken from write");

	chk_mid_reset: assert property ( // [R6]
		@(posedge pclk) disable iff (!presetn)
		!$past(presetn) |-> words_q[1] == 16'h4936 &&
		                    drive.main_out_level[2] == 3'h6 &&
		                    drive.frame_ref_level[0] == 3'h4)
		else $error("level word reset value wrong");

	chk_ref_levels: assert property ( // [R7]
		@(posedge pclk) disable iff (!presetn)
		wr_mid |-> ##2 drive.frame_ref_level[2] == $past(pwdata[14:12], 2) &&
		               drive.frame_ref_level[1] == $past(pwdata[11:9], 2) &&
		               drive.main_out_level[3] == $past(pwdata[5:3], 2))
		else $error("frame reference levels not taken from write");

	chk_bias_reset: assert property ( // [R9]
		@(posedge pclk) disable iff (!presetn)
		!$past(presetn) |-> words_q[2] == 16'hb6dc && drive.fabric_clk_on &&
		                    drive.frame_ref_bias[3] == 3'h3)
		else $error("bias word reset value wrong");

	chk_logic_reset: assert property ( // [R11]
		@(posedge pclk) disable iff (!presetn)
		!$past(presetn) |-> words_q[3] == 16'h0001 && drive.fabric_ref_on &&
		                    words_q[4] == 16'h0120)
		else $error("logic words reset value wrong");

	chk_ref_bias_gate: assert property ( // [R12]
		@(posedge pclk) disable iff (!presetn)
		drive.fabric_ref_bias == ($past(words_q[4][3:2]) == 2'h0 ?
		                          $past(words_q[3][14:13]) : 2'h0))
		else $error("fabric reference bias not gated by LVDS format");

	chk_clk_bias_gate: assert property ( // [R13]
		@(posedge pclk) disable iff (!presetn)
		drive.fabric_clk_bias == ($past(words_q[4][1:0]) == 2'h0 ?
		                          $past(words_q[3][12:11]) : 2'h0))
		else $error("fabric clock bias not gated by LVDS format");

	chk_ref_level_gate: assert property ( // [R16]
		@(posedge pclk) disable iff (!presetn)
		drive.fabric_ref_level == ($past(words_q[4][3:2]) == 2'h2 ?
		                           $past(words_q[3][6:4]) : 3'h0))
		else $error("fabric reference level not gated by CML format");

	chk_clk_level_gate: assert property ( // [R17]
		@(posedge pclk) disable iff (!presetn)
		drive.fabric_clk_level == ($past(words_q[4][1:0]) == 2'h2 ?
		                           $past(words_q[3][3:1]) : 3'h0))
		else $error("fabric clock level not gated by CML format");

	chk_low_reset: assert property ( // [R2] [R3] [R4] [R5]
		@(posedge pclk) disable iff (!presetn)
		!$past(presetn) |-> words_q[0] == 16'h36ff &&
		                    drive.main_out_level[1] == 3'h6 &&
		                    drive.main_out_level[0] == 3'h6 &&
		                    drive.main_out_on == 4'hf &&
		                    drive.frame_ref_on == 4'hf)
		else $error("enable word reset value wrong");

	chk_main_enables: assert property ( // [R5]
		@(posedge pclk) disable iff (!presetn)
		wr_low_lo |-> ##2 drive.main_out_on == $past(pwdata[3:0], 2))
		else $error("main output enables not taken from write");

	chk_ref_bias: assert property ( // [R10]
		@(posedge pclk) disable iff (!presetn)
		wr_bias |-> ##2 drive.frame_ref_bias[3] == $past(pwdata[14:12], 2) &&
		                drive.frame_ref_bias[2] == $past(pwdata[11:9], 2) &&
		                drive.frame_ref_bias[1] == $past(pwdata[8:6], 2) &&
		                drive.frame_ref_bias[0] == $past(pwdata[5:3], 2))
		else $error("frame reference biases not taken from write");

	chk_ref3_level: assert property ( // [R9]
		@(posedge pclk) disable iff (!presetn)
		wr_bias |-> ##2 drive.frame_ref_level[3] == $past(pwdata[2:0], 2) &&
		                drive.fabric_clk_on == $past(pwdata[15], 2))
		else $error("bias word level or clock enable not taken");

	chk_fabric_ref_on: assert property ( // [R11]
		@(posedge pclk) disable iff (!presetn)
		wr_logic |-> ##2 drive.fabric_ref_on == $past(pwdata[0], 2))
		else $error("fabric reference enable not taken from write");

	chk_ref_predrive: assert property ( // [R14]
		@(posedge pclk) disable iff (!presetn)
		wr_logic |-> ##2 drive.fabric_ref_predrive == $past(pwdata[10:9], 2))
		else $error("fabric reference predrive not taken from write");

	chk_clk_predrive: assert property ( // [R15]
		@(posedge pclk) disable iff (!presetn)
		wr_logic |-> ##2 drive.fabric_clk_predrive == $past(pwdata[8:7], 2))
		else $error("fabric clock predrive not taken from write");

	chk_driver_type: assert property ( // [R19]
		@(posedge pclk) disable iff (!presetn)
		drive.fabric_clk_driver_type == $past(words_q[4][1:0]) &&
		drive.fabric_ref_driver_type == $past(words_q[4][3:2]))
		else $error("fabric driver types not taken from stored word");

	chk_unmapped_err: assert property (
		@(posedge pclk) disable iff (!presetn)
		psel && !penable && !hit |=> pslverr && prdata == 32'h0000_0000)
		else $error("unmapped access not flagged");

	chk_read_data: assert property (
		@(posedge pclk) disable iff (!presetn)
		psel && !penable && !pwrite && hit |=>
		prdata == {16'h0000, $past(words_q[sel_idx])})
		else $error("read data does not match the stored word");

	chk_reserved_zero: assert property ( // [R18]
		@(posedge pclk) disable iff (!presetn)
		pready |-> prdata[31:16] == 16'h0000 && !words_q[0][15] &&
		           !words_q[0][14] && words_q[4][15:9] == 7'h00)
		else $error("reserved bits not zero");

	chk_drive_steady: assert property ( // [R20]
		@(posedge pclk) disable iff (!presetn)
		!$past(wr_en) && !$past(wr_en, 2) |-> $stable(drive))
		else $error("driver controls changed without a write");

	chk_apb_ready: assert property (
		@(posedge pclk) disable iff (!presetn)
		psel && !penable |=> pready ##1 !pready)
		else $error("ready not given in the access phase");

	cov_write_low: cover property (
		@(posedge pclk) disable iff (!presetn) wr_low_hi);

	cov_cml_level: cover property (
		@(posedge pclk) disable iff (!presetn) drive.fabric_ref_level != 3'h0);

	cov_unmapped: cover property (
		@(posedge pclk) disable iff (!presetn) pready && pslverr);

	cov_lvds_bias: cover property (
		@(posedge pclk) disable iff (!presetn) drive.fabric_clk_bias != 2'h0);

	cov_write_bias: cover property (
		@(posedge pclk) disable iff (!presetn) wr_bias);

endmodule

/* testbench.sv */
`timescale 1ns/100ps

module testbench
	import obcfg_pkg::*;
;
	// ************************************************************
	// Stimulus, model and bookkeeping.
	// ************************************************************
	logic         pclk    = 1'b0;
	logic         presetn = 1'b0;
	logic         psel    = 1'b0;
	logic         penable = 1'b0;
	logic         pwrite  = 1'b0;
	logic [7:0]   paddr   = 8'h00;
	logic [31:0]  pwdata  = 32'h0;
	logic [3:0]   pstrb   = 4'h0;
	logic [31:0]  prdata;
	logic         pready;
	logic         pslverr;
	obcfg_drive_t drive;
	obcfg_words_t mw;
	logic [31:0]  rd;
	logic         er;
	int           num_errors = 0;
	int           n_compared = 0;
	int           cyc        = 0;
	localparam obcfg_words_t RSTW = {16'h0120, 16'h0001, 16'hb6dc,
		16'h4936, 16'h36ff};
	localparam obcfg_words_t MASK = {16'h01ff, 16'h7fff, 16'hffff,
		16'h7fff, 16'h3fff};

	obcfg_regs dut_u (
		.pclk    (pclk),
		.presetn (presetn),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.pstrb   (pstrb),
		.prdata  (prdata),
		.pready  (pready),
		.pslverr (pslverr),
		.drive   (drive)
	);

	always #12.5 pclk = ~pclk;

	// Bias outputs only pass in LVDS, level outputs only in CML.
	function automatic obcfg_drive_t exp_drv(obcfg_words_t w);
		obcfg_drive_t d;
		d.main_out_on = w[0][3:0];
		d.frame_ref_on = w[0][7:4];
		d.main_out_level = {w[1][5:3], w[1][2:0], w[0][13:11], w[0][10:8]};
		d.frame_ref_level = {w[2][2:0], w[1][14:12], w[1][11:9], w[1][8:6]};
		d.frame_ref_bias = {w[2][14:12], w[2][11:9], w[2][8:6], w[2][5:3]};
		d.fabric_clk_on = w[2][15];
		d.fabric_ref_on = w[3][0];
		d.fabric_clk_driver_type = w[4][1:0];
		d.fabric_ref_driver_type = w[4][3:2];
		d.fabric_subsys_on = w[4][5];
		d.fabric_pre_div = w[4][8:6];
		d.fabric_clk_predrive = w[3][8:7];
		d.fabric_ref_predrive = w[3][10:9];
		d.fabric_clk_bias = (w[4][1:0] == 2'h0) ? w[3][12:11] : 2'h0;
		d.fabric_ref_bias = (w[4][3:2] == 2'h0) ? w[3][14:13] : 2'h0;
		d.fabric_clk_level = (w[4][1:0] == 2'h2) ? w[3][3:1] : 3'h0;
		d.fabric_ref_level = (w[4][3:2] == 2'h2) ? w[3][6:4] : 3'h0;
		return d;
	endfunction

	task automatic check(string nm, logic [127:0] seen, logic [127:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic finish_test;
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// One transfer, entered right after a rising edge; the caller releases.
	task automatic apb(logic w, logic [7:0] a, logic [15:0] d, logic [3:0] s);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {16'h0, d};
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
	endtask

	task automatic idle;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(int i, logic [15:0] d, logic [3:0] s);
		apb(1'b1, 8'(4 * (i + 4)), d & MASK[i], s);
		check("write error flag", 128'(er), 128'(0));
		for (int b = 0; b < 2; b++) begin
			if (s[b]) mw[i][8*b+:8] = d[8*b+:8] & MASK[i][8*b+:8];
		end
	endtask

	task automatic rdchk(int i);
		apb(1'b0, 8'(4 * (i + 4)), 16'h0, 4'h0);
		check("read word", 128'(rd), 128'({16'h0, mw[i]}));
		check("read error flag", 128'(er), 128'(0));
	endtask

	task automatic drvchk;
		idle;
		@(posedge pclk);
		check("drive", 128'(drive), 128'(exp_drv(mw)));
	endtask

	always @(posedge pclk) begin
		cyc++;
		if (cyc == 5000) begin
			num_errors++;
			finish_test;
		end
	end

	// ************************************************************
	// Test sequence.
	// ************************************************************
	initial begin
		int i;
		logic [7:0] bad [4] = '{8'h0c, 8'h24, 8'h11, 8'hfc};
		void'($urandom(32'h731a));
		mw = RSTW;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		check("reset drive", 128'(drive), 128'(exp_drv(RSTW)));
		for (i = 0; i < 5; i++) rdchk(i);
		idle;
		$display("test reset values done");
		for (i = 0; i < 5; i++) wr(i, 16'hffff, 4'h3);
		for (i = 0; i < 5; i++) rdchk(i);
		drvchk;
		$display("test all ones done");
		repeat (40) begin
			i = $urandom % 5;
			wr(i, 16'($urandom), 4'($urandom));
			if (i == 1) wr(2, 16'($urandom), 4'h3);
			drvchk;
			rdchk(i);
		end
		idle;
		$display("test random writes done");
		for (i = 0; i < 4; i++) begin
			wr(3, 16'h7ffe, 4'h3);
			wr(4, 16'h0120 | 16'(i) | 16'((3 - i) << 2), 4'h3);
			drvchk;
		end
		$display("test driver types done");
		foreach (bad[k]) begin
			apb(1'b1, bad[k], 16'hffff, 4'h3);
			check("unmapped write error", 128'(er), 128'(1));
			apb(1'b0, bad[k], 16'h0, 4'h0);
			check("unmapped read error", 128'(er), 128'(1));
			check("unmapped read data", 128'(rd), 128'(0));
		end
		drvchk;
		for (i = 0; i < 5; i++) rdchk(i);
		idle;
		$display("test unmapped done");
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		mw = RSTW;
		@(posedge pclk);
		check("rereset drive", 128'(drive), 128'(exp_drv(RSTW)));
		for (i = 0; i < 5; i++) rdchk(i);
		idle;
		$display("test second reset done");
		finish_test;
	end
endmodule
